// file: common/ebst_pkg.sv
package ebst_pkg;

  // Clock rate of the block and the fine timebase derived from it.
  localparam int CLOCK_MHZ  = 100;
  localparam int CLOCK_NS   = 1000 / CLOCK_MHZ;
  // Clocks per core cycle; the core cycle is an enable from a divider.
  localparam int CORE_TICKS = 2;
  // Clocks per half core cycle, used by the half-strobe options.
  localparam int HALF_TICKS = 1;
  // Width of the per-state clock counter.
  localparam int LEN_W      = 12;
  // Entries of the request buffer.
  localparam int BUF_DEPTH  = 2;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_ASTRB  = 4'h1,
    ST_AHOLD  = 4'h2,
    ST_WSETUP = 4'h3,
    ST_WSTRB  = 4'h4,
    ST_WHOLD  = 4'h5,
    ST_RSETUP = 4'h6,
    ST_RSTRB  = 4'h7,
    ST_RHOLD  = 4'h8
  } ebst_state_e;

  localparam ebst_state_e STATE_RESET = ST_IDLE;
  localparam logic [LEN_W-1:0] CNT_RESET = 12'h000;

endpackage : ebst_pkg

// file: src/ebst_buf.sv
`timescale 1ns/10ps
module ebst_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0]   count_r;
  logic [PTR_W-1:0] wr_ptr_nxt;
  logic [PTR_W-1:0] rd_ptr_nxt;
  logic [PTR_W:0]   count_nxt;
  logic             push;
  logic             pop;

  // Flags are registered so the ready seen by the source is a clean flop.
  logic             ready_r;
  logic             valid_r;

  assign in_ready  = ready_r;
  assign out_valid = valid_r;
  assign out_data  = mem_r[rd_ptr_r];

  always_comb begin
    push       = in_valid && ready_r;
    pop        = out_ready && valid_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      wr_ptr_nxt = (32'(wr_ptr_r) == DEPTH - 1) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (32'(rd_ptr_r) == DEPTH - 1) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b1;
      valid_r  <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      ready_r  <= 32'(count_nxt) < DEPTH;
      valid_r  <= count_nxt != '0;
    end
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule : ebst_buf

// file: src/ebst_top.sv
`timescale 1ns/10ps
// Overview of operation
// [RL1] Address and selects valid for write setup
// [RL2] Write strobe lasts count plus one; hold
// [RL3] Half option delays write strobe leading edge
// [RL4] Latch strobe only in two multiplexed modes
// [RL5] Muxed address appears with latch strobe
// [RL6] Latch strobe count plus one, then hold
// [RL7] Half option ends latch strobe early
// [RL8] Muxed read address hold uses read setup
// [RL9] Address and selects valid for read setup
// [RL10] Read strobe lasts count plus one; hold
// [RL11] Half option delays read strobe leading edge
// [RL12] Page hits use page access count
// [RL13] Memory ready settles three cycles before edge
// [RL14] Polarity changes sense, never timing
// [RL15] Not ready stretches strobe until ready seen
module ebst_top import ebst_pkg::*; #(
  parameter int ADDR_W   = 24,
  parameter int DATA_W   = 16,
  parameter int CS_W     = 4,
  parameter int BL_W     = 2,
  parameter int CNT_W    = 6,
  parameter int PAGE_LSB = 8
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  // Request stream
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [CS_W-1:0]   req_cs,
  input  wire logic [BL_W-1:0]   req_bl,
  // Read response and busy status
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   busy,
  // Timing configuration
  input  wire logic [CNT_W-1:0]  write_setup_cycles,
  input  wire logic [CNT_W-1:0]  write_strobe_cycles,
  input  wire logic [CNT_W-1:0]  write_hold_cycles,
  input  wire logic              half_write_strobe_opt,
  input  wire logic [CNT_W-1:0]  addr_setup_cycles,
  input  wire logic [CNT_W-1:0]  addr_hold_cycles,
  input  wire logic              half_latch_strobe_opt,
  input  wire logic [CNT_W-1:0]  read_setup_cycles,
  input  wire logic [CNT_W-1:0]  read_strobe_cycles,
  input  wire logic [CNT_W-1:0]  read_hold_cycles,
  input  wire logic              half_read_strobe_opt,
  input  wire logic [CNT_W-1:0]  page_access_cycles,
  // Mode configuration
  input  wire logic              page_mode_en,
  input  wire logic              mux_mode_byte_wide,
  input  wire logic              mux_mode_half_word,
  input  wire logic              nand_mode_en,
  input  wire logic              ready_wait_en,
  input  wire logic              strobe_active_high,
  input  wire logic              select_active_high,
  // External memory pins
  output logic                   write_strobe,
  output logic                   nand_write_strobe,
  output logic                   read_strobe,
  output logic                   nand_read_strobe,
  output logic                   address_latch_strobe,
  output logic [CS_W-1:0]        chip_select_lines,
  output logic [BL_W-1:0]        byte_lane_selects,
  output logic [ADDR_W-1:0]      extra_address_lines,
  output logic [DATA_W-1:0]      muxed_addr_data_bus_o,
  output logic                   muxed_addr_data_bus_oe,
  input  wire logic [DATA_W-1:0] muxed_addr_data_bus_i,
  input  wire logic              ready_wait_input
);

  localparam int REQ_W = 1 + CS_W + BL_W + ADDR_W + DATA_W;
  localparam logic [LEN_W-1:0] CT  = LEN_W'(CORE_TICKS);
  localparam logic [LEN_W-1:0] HT  = LEN_W'(HALF_TICKS);
  localparam logic [LEN_W-1:0] AEX = LEN_W'(CORE_TICKS - HALF_TICKS);

  logic              buf_valid;
  logic              take;
  logic [REQ_W-1:0]  buf_data;
  logic              mux;
  logic              hit_in;
  logic [ADDR_W-1:0] b_addr;

  ebst_state_e       state_r, state_nxt;
  logic [LEN_W-1:0]  cnt_r, cnt_nxt;
  logic [LEN_W-1:0]  tick_r, tick_nxt;
  logic              core_tick_r, core_tick_nxt;
  logic              wr_r, wr_nxt;
  logic              hit_r, hit_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic [CS_W-1:0]   cs_r, cs_nxt;
  logic [BL_W-1:0]   bl_r, bl_nxt;
  logic [ADDR_W-1:PAGE_LSB] page_r, page_nxt;
  logic              page_ok_r, page_ok_nxt;
  logic              rsp_valid_nxt;
  logic [DATA_W-1:0] rsp_data_nxt;
  // Pin inputs pass two flops; only the second stage is read.
  logic [DATA_W-1:0] ad_s1_r, ad_s2_r;
  logic              rdy_s1_r, rdy_s2_r;
  logic              we_nxt, nwe_nxt, re_nxt, nre_nxt, ale_nxt, oe_nxt;
  logic [CS_W-1:0]   csl_nxt;
  logic [BL_W-1:0]   bls_nxt;
  logic [ADDR_W-1:0] xa_nxt;
  logic [DATA_W-1:0] ad_nxt;

  ebst_buf #(.WIDTH(REQ_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clock    (clock),
    .reset    (reset),
    .in_valid (req_valid),
    .in_ready (req_ready),
    .in_data  ({req_write, req_cs, req_bl, req_addr, req_wdata}),
    .out_valid(buf_valid),
    .out_ready(take),
    .out_data (buf_data)
  );

  function automatic logic [LEN_W-1:0] cyc(input logic [CNT_W-1:0] n);
    return LEN_W'(n) * CT;
  endfunction : cyc

  // Length of each state in clocks; strobe states are never zero.
  function automatic logic [LEN_W-1:0] lenf(input ebst_state_e st,
                                            input logic m,
                                            input logic h);
    logic [LEN_W-1:0] ext;
    ext = half_latch_strobe_opt ? AEX : '0;
    unique case (st)
      ST_ASTRB:  lenf = cyc(addr_setup_cycles) + CT - ext; // RL6 RL7
      ST_AHOLD:  lenf = cyc(addr_hold_cycles) + ext; // RL6 RL7
      ST_WSETUP: lenf = cyc(write_setup_cycles)
                        + (half_write_strobe_opt ? HT : '0); // RL1 RL3
      ST_WSTRB:  lenf = cyc(write_strobe_cycles) + CT
                        - (half_write_strobe_opt ? HT : '0); // RL2 RL3
      ST_WHOLD:  lenf = cyc(write_hold_cycles); // RL2
      ST_RSETUP: lenf = cyc(read_setup_cycles) + (m ? ext : '0)
                        + (half_read_strobe_opt ? HT : '0); // RL8 RL9 RL11
      ST_RSTRB:  lenf = cyc(h ? page_access_cycles : read_strobe_cycles)
                        + CT - (half_read_strobe_opt ? HT : '0); // RL10 RL12
      ST_RHOLD:  lenf = cyc(read_hold_cycles); // RL10
      default:   lenf = 12'h001;
    endcase
  endfunction : lenf

  function automatic ebst_state_e succ(input ebst_state_e st,
                                       input logic w, input logic m);
    unique case (st)
      ST_IDLE:   succ = m ? ST_ASTRB : (w ? ST_WSETUP : ST_RSETUP); // RL4
      ST_ASTRB:  succ = w ? ST_AHOLD : ST_RSETUP; // RL8
      ST_AHOLD:  succ = ST_WSETUP;
      ST_WSETUP: succ = ST_WSTRB;
      ST_WSTRB:  succ = ST_WHOLD;
      ST_RSETUP: succ = ST_RSTRB;
      ST_RSTRB:  succ = ST_RHOLD;
      default:   succ = ST_IDLE;
    endcase
  endfunction : succ

  // Zero-length setup and hold states are passed over in the same cycle.
  function automatic ebst_state_e step(input ebst_state_e st, input logic w,
                                       input logic m, input logic h);
    ebst_state_e n;
    n = succ(st, w, m);
    for (int i = 0; i < 2; i++) begin
      if (n != ST_IDLE && lenf(n, m, h) == '0) begin
        n = succ(n, w, m);
      end
    end
    return n;
  endfunction : step

  assign mux    = mux_mode_byte_wide | mux_mode_half_word;
  assign b_addr = buf_data[DATA_W +: ADDR_W];
  assign hit_in = page_mode_en && page_ok_r && !buf_data[REQ_W-1]
                  && b_addr[ADDR_W-1:PAGE_LSB] == page_r; // RL12

  always_comb begin
    take          = 1'b0;
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    wr_nxt        = wr_r;
    hit_nxt       = hit_r;
    addr_nxt      = addr_r;
    data_nxt      = data_r;
    cs_nxt        = cs_r;
    bl_nxt        = bl_r;
    page_nxt      = page_r;
    page_ok_nxt   = page_ok_r && page_mode_en;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt  = rsp_data;
    tick_nxt      = (tick_r == CT - 1'b1) ? '0 : tick_r + 1'b1;
    core_tick_nxt = tick_nxt == '0;
    if (state_r == ST_IDLE) begin
      // Transfers start on a core clock edge only.
      if (core_tick_r && buf_valid) begin
        take        = 1'b1;
        wr_nxt      = buf_data[REQ_W-1];
        cs_nxt      = buf_data[REQ_W-2 -: CS_W];
        bl_nxt      = buf_data[DATA_W+ADDR_W +: BL_W];
        addr_nxt    = b_addr;
        data_nxt    = buf_data[DATA_W-1:0];
        hit_nxt     = hit_in;
        page_nxt    = b_addr[ADDR_W-1:PAGE_LSB];
        page_ok_nxt = page_mode_en && !wr_nxt;
        state_nxt   = step(ST_IDLE, wr_nxt, mux, hit_in);
        cnt_nxt     = lenf(state_nxt, mux, hit_in) - 1'b1;
      end
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end else if ((state_r == ST_WSTRB || state_r == ST_RSTRB)
                 && ready_wait_en && !rdy_s2_r) begin
      cnt_nxt = '0; // RL15 RL13
    end else begin
      if (state_r == ST_RSTRB) begin
        rsp_valid_nxt = 1'b1;
        rsp_data_nxt  = ad_s2_r;
      end
      state_nxt = step(state_r, wr_r, mux, hit_r);
      cnt_nxt   = (state_nxt == ST_IDLE) ? '0
                  : lenf(state_nxt, mux, hit_r) - 1'b1;
    end
    // Pins follow the next state so they change on the same edge as it.
    we_nxt  = state_nxt == ST_WSTRB && !nand_mode_en;
    nwe_nxt = state_nxt == ST_WSTRB && nand_mode_en;
    re_nxt  = state_nxt == ST_RSTRB && !nand_mode_en;
    nre_nxt = state_nxt == ST_RSTRB && nand_mode_en;
    ale_nxt = state_nxt == ST_ASTRB && mux; // RL4
    csl_nxt = (state_nxt != ST_IDLE) ? cs_nxt : '0; // RL1 RL9
    bls_nxt = (state_nxt != ST_IDLE) ? bl_nxt : '0;
    // Polarity inverts sense only; the same state drives both senses.
    we_nxt  = we_nxt ~^ strobe_active_high; // RL14
    nwe_nxt = nwe_nxt ~^ strobe_active_high;
    re_nxt  = re_nxt ~^ strobe_active_high;
    nre_nxt = nre_nxt ~^ strobe_active_high;
    ale_nxt = ale_nxt ~^ strobe_active_high;
    csl_nxt = select_active_high ? csl_nxt : ~csl_nxt;
    bls_nxt = select_active_high ? bls_nxt : ~bls_nxt;
    if (mux_mode_byte_wide) begin
      xa_nxt = addr_nxt >> 8;
    end else if (mux_mode_half_word) begin
      xa_nxt = addr_nxt >> 16;
    end else begin
      xa_nxt = addr_nxt;
    end
    if (mux && (state_nxt == ST_ASTRB || state_nxt == ST_AHOLD
                || state_nxt == ST_RSETUP)) begin
      // Address goes out on the same edge as the latch strobe.
      oe_nxt = 1'b1; // RL5 RL8
      ad_nxt = mux_mode_byte_wide ? DATA_W'(addr_nxt[7:0])
                                  : addr_nxt[DATA_W-1:0];
    end else begin
      oe_nxt = wr_nxt && state_nxt != ST_IDLE;
      ad_nxt = data_nxt;
    end
  end

  always_ff @(posedge clock) begin
    ad_s1_r  <= muxed_addr_data_bus_i;
    ad_s2_r  <= ad_s1_r;
    rdy_s1_r <= ready_wait_input;
    rdy_s2_r <= rdy_s1_r;
    addr_r   <= addr_nxt;
    data_r   <= data_nxt;
    page_r   <= page_nxt;
    rsp_data <= rsp_data_nxt;
    if (reset) begin
      state_r                <= STATE_RESET;
      cnt_r                  <= CNT_RESET;
      tick_r                 <= CNT_RESET;
      core_tick_r            <= 1'b0;
      wr_r                   <= 1'b0;
      hit_r                  <= 1'b0;
      cs_r                   <= '0;
      bl_r                   <= '0;
      page_ok_r              <= 1'b0;
      rsp_valid              <= 1'b0;
      busy                   <= 1'b0;
      write_strobe           <= ~strobe_active_high;
      nand_write_strobe      <= ~strobe_active_high;
      read_strobe            <= ~strobe_active_high;
      nand_read_strobe       <= ~strobe_active_high;
      address_latch_strobe   <= ~strobe_active_high;
      chip_select_lines      <= {CS_W{~select_active_high}};
      byte_lane_selects      <= {BL_W{~select_active_high}};
      extra_address_lines    <= '0;
      muxed_addr_data_bus_o  <= '0;
      muxed_addr_data_bus_oe <= 1'b0;
    end else begin
      state_r                <= state_nxt;
      cnt_r                  <= cnt_nxt;
      tick_r                 <= tick_nxt;
      core_tick_r            <= core_tick_nxt;
      wr_r                   <= wr_nxt;
      hit_r                  <= hit_nxt;
      cs_r                   <= cs_nxt;
      bl_r                   <= bl_nxt;
      page_ok_r              <= page_ok_nxt;
      rsp_valid              <= rsp_valid_nxt;
      busy                   <= state_nxt != ST_IDLE;
      write_strobe           <= we_nxt;
      nand_write_strobe      <= nwe_nxt;
      read_strobe            <= re_nxt;
      nand_read_strobe       <= nre_nxt;
      address_latch_strobe   <= ale_nxt;
      chip_select_lines      <= csl_nxt;
      byte_lane_selects      <= bls_nxt;
      extra_address_lines    <= xa_nxt;
      muxed_addr_data_bus_o  <= ad_nxt;
      muxed_addr_data_bus_oe <= oe_nxt;
    end
  end

  // Helper: clocks already spent in the current state, of any kind.
  logic [LEN_W-1:0] run_r;
  always_ff @(posedge clock) begin
    if (reset || state_nxt != state_r) begin
      run_r <= '0;
    end else begin
      run_r <= run_r + 1'b1;
    end
  end

  wstrb_width_a: assert property (@(posedge clock) disable iff (reset) // RL2
    (state_r == ST_WSTRB && state_nxt != ST_WSTRB && !ready_wait_en)
    |-> run_r + 1'b1 == lenf(ST_WSTRB, mux, hit_r))
    else $error("write strobe width wrong");

  rstrb_width_a: assert property (@(posedge clock) disable iff (reset) // RL10
    (state_r == ST_RSTRB && state_nxt != ST_RSTRB && !ready_wait_en)
    |-> run_r + 1'b1 == lenf(ST_RSTRB, mux, hit_r))
    else $error("read strobe width wrong");

  ale_mode_a: assert property (@(posedge clock) disable iff (reset) // RL4
    state_r == ST_ASTRB |-> mux)
    else $error("latch strobe outside multiplexed mode");

  ale_addr_a: assert property (@(posedge clock) disable iff (reset) // RL5
    $rose(state_r == ST_ASTRB) |-> muxed_addr_data_bus_oe)
    else $error("address not driven with latch strobe");

  mux_read_a: assert property (@(posedge clock) disable iff (reset) // RL8
    (state_r == ST_ASTRB && !wr_r) |=> state_r != ST_AHOLD)
    else $error("muxed read used address hold state");

  wsetup_sel_a: assert property (@(posedge clock) disable iff (reset) // RL1
    $rose(state_r == ST_WSTRB) && $past(busy) |-> $stable(chip_select_lines))
    else $error("selects changed at write strobe edge");

  pol_sense_a: assert property (@(posedge clock) disable iff (reset) // RL14
    (state_r == ST_RSTRB && !nand_mode_en)
    |-> read_strobe == strobe_active_high)
    else $error("read strobe sense wrong");

  wait_hold_a: assert property (@(posedge clock) disable iff (reset) // RL15
    (state_r == ST_WSTRB && cnt_r == '0 && ready_wait_en && !rdy_s2_r)
    |=> state_r == ST_WSTRB)
    else $error("strobe ended while not ready");
  // Expected setup is rebuilt from the ports, not from the length function.
  half_we_a: assert property (@(posedge clock) disable iff (reset) // RL3
    (state_r == ST_WSETUP && state_nxt != ST_WSETUP)
    |-> run_r + 1'b1 == LEN_W'(write_setup_cycles) * CT
                        + (half_write_strobe_opt ? HT : '0))
    else $error("write setup length wrong");

endmodule : ebst_top

// file: tb/ebst_mem.sv
`timescale 1ns/10ps
module ebst_mem (
  // Clock and bench settings
  input  wire logic        clock,
  input  wire logic        strobe_active_high,
  input  wire logic [7:0]  wait_clks,
  // Strobes from the device
  input  wire logic        write_strobe,
  input  wire logic        nand_write_strobe,
  input  wire logic        read_strobe,
  input  wire logic        nand_read_strobe,
  // Data lines and ready
  input  wire logic [15:0] muxed_addr_data_bus_o,
  input  wire logic        muxed_addr_data_bus_oe,
  output logic      [15:0] muxed_addr_data_bus_i,
  output logic             ready_wait_input
);
  logic [15:0] stored_r = 16'h0000;
  logic [15:0] junk_r   = 16'h5A5A;
  logic [7:0]  wcnt_r   = 8'h00;
  logic        wr_act;
  logic        rd_act;
  assign wr_act = (write_strobe === strobe_active_high) ||
                  (nand_write_strobe === strobe_active_high);
  assign rd_act = (read_strobe === strobe_active_high) ||
                  (nand_read_strobe === strobe_active_high);
  // A released bus toggles, so stale data never passes for a read.
  assign muxed_addr_data_bus_i = rd_act ? stored_r : junk_r;
  // Ready stays valid and only rises once the strobe has run long enough.
  assign ready_wait_input = (wcnt_r >= wait_clks);
  always @(posedge clock) begin
    junk_r <= ~junk_r;
    if (wr_act && muxed_addr_data_bus_oe) begin
      stored_r <= muxed_addr_data_bus_o;
    end
    if (wr_act || rd_act) begin
      wcnt_r <= wcnt_r + 8'h01;
    end else begin
      wcnt_r <= 8'h00;
    end
  end
endmodule : ebst_mem

// file: tb/ebst_top_tb_top.sv
`timescale 1ns/10ps
module ebst_top_tb_top import ebst_pkg::*;;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid, req_ready, req_write, rsp_valid, busy;
  logic [23:0] req_addr, extra_address_lines, xa;
  logic [15:0] req_wdata, rsp_data, rd, at_ale;
  logic [15:0] muxed_addr_data_bus_o, muxed_addr_data_bus_i;
  logic [3:0]  req_cs, chip_select_lines;
  logic [1:0]  req_bl, byte_lane_selects, bls;
  logic [5:0]  c_ws, c_wst, c_wh, c_as, c_ah, c_rs, c_rsb, c_rh, c_pa;
  logic        o_hw, o_hl, o_hr, m_pg, m_b8, m_h16, m_nd, m_rw, m_sah, m_sh;
  logic        write_strobe, nand_write_strobe, read_strobe;
  logic        nand_read_strobe, address_latch_strobe;
  logic        muxed_addr_data_bus_oe, ready_wait_input;
  logic [7:0]  wait_clks;
  int          fails = 0, samples_checked = 0;
  int          ale_n, gap_n, stb_n, hold_n, rsp_n;

  always #(CLOCK_NS / 2) clock = ~clock;

  ebst_top i_dut (.clock, .reset, .req_valid, .req_ready, .req_write,
    .req_addr, .req_wdata, .req_cs, .req_bl, .rsp_valid, .rsp_data, .busy,
    .write_setup_cycles(c_ws), .write_strobe_cycles(c_wst),
    .write_hold_cycles(c_wh), .half_write_strobe_opt(o_hw),
    .addr_setup_cycles(c_as), .addr_hold_cycles(c_ah),
    .half_latch_strobe_opt(o_hl), .read_setup_cycles(c_rs),
    .read_strobe_cycles(c_rsb), .read_hold_cycles(c_rh),
    .half_read_strobe_opt(o_hr), .page_access_cycles(c_pa),
    .page_mode_en(m_pg), .mux_mode_byte_wide(m_b8),
    .mux_mode_half_word(m_h16), .nand_mode_en(m_nd), .ready_wait_en(m_rw),
    .strobe_active_high(m_sah), .select_active_high(m_sh), .write_strobe,
    .nand_write_strobe, .read_strobe, .nand_read_strobe,
    .address_latch_strobe, .chip_select_lines, .byte_lane_selects,
    .extra_address_lines, .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe,
    .muxed_addr_data_bus_i, .ready_wait_input);

  ebst_mem i_mem (.clock, .strobe_active_high(m_sah), .wait_clks,
    .write_strobe, .nand_write_strobe, .read_strobe, .nand_read_strobe,
    .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe,
    .muxed_addr_data_bus_i, .ready_wait_input);

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Runs one transfer and measures every phase in clocks at the pins.
  task automatic xfer(input logic w, input logic [23:0] a,
                      input logic [15:0] d);
    int   n;
    logic s;
    logic c;
    logic seen;
    n = 0;
    seen = 1'b0;
    {ale_n, gap_n, stb_n, hold_n, rsp_n} = '0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    while (n < 400) begin
      s = w ? (m_nd ? nand_write_strobe : write_strobe)
            : (m_nd ? nand_read_strobe : read_strobe);
      s = (s === m_sah);
      c = (chip_select_lines !== {4{~m_sh}});
      if (address_latch_strobe === m_sah) begin
        if (ale_n == 0) at_ale = muxed_addr_data_bus_o;
        ale_n++;
      end else if (s) begin
        if (stb_n == 0) begin
          xa  = extra_address_lines;
          bls = byte_lane_selects;
        end
        stb_n++;
        seen = 1'b1;
      end else if (c && !seen) gap_n++;
      else if (c) hold_n++;
      else if (seen) break;
      if (rsp_valid === 1'b1) begin
        rsp_n++;
        rd = rsp_data;
      end
      @(negedge clock);
      n++;
    end
    // A hang in either loop counts against the run.
    if (n >= 400) begin
      fails++;
      finish_test();
    end
    repeat (3) begin
      if (rsp_valid === 1'b1) begin
        rsp_n++;
        rd = rsp_data;
      end
      @(negedge clock);
    end
  endtask : xfer

  task automatic t_write;
    {c_ws, c_wst, c_wh} = {6'h01, 6'h00, 6'h01};
    xfer(1'b1, 24'h123456, 16'hBEEF);
    check(ale_n, 0);
    check(gap_n, 2);
    check(stb_n, 2);
    check(hold_n, 2);
    check(xa, 24'h123456);
    check(bls, 2'h3);
    check(rsp_n, 0);
    o_hw = 1'b1;
    c_wst = 6'h01;
    xfer(1'b1, 24'h123456, 16'hBEEF);
    check(gap_n, 3);
    check(stb_n, 3);
    {o_hw, m_nd, c_ws, c_wh} = {1'b0, 1'b1, 6'h02, 6'h00};
    xfer(1'b1, 24'h000010, 16'h0F0F);
    check(gap_n, 4);
    check(stb_n, 4);
    check(hold_n, 0);
    m_nd = 1'b0;
    $display("test write done");
  endtask : t_write

  task automatic t_polarity;
    {m_sah, m_sh, c_ws, c_wst, c_wh} = {2'b00, 6'h01, 6'h00, 6'h01};
    repeat (2) @(negedge clock);
    check(write_strobe, 1'b1);
    xfer(1'b1, 24'h123456, 16'hBEEF);
    check(gap_n, 2);
    check(stb_n, 2);
    check(hold_n, 2);
    check(bls, 2'h0);
    {m_sah, m_sh} = 2'b11;
    repeat (2) @(negedge clock);
    $display("test polarity done");
  endtask : t_polarity

  task automatic t_mux;
    {m_b8, c_as, c_ah, c_ws, c_wst, c_wh} = {1'b1, 6'h01, 6'h01, 6'h01,
                                            6'h00, 6'h00};
    xfer(1'b1, 24'hABCDEF, 16'h1357);
    check(ale_n, 4);
    check(gap_n, 4);
    check(at_ale, 16'h00EF);
    check(xa, 24'h00ABCD);
    {m_b8, m_h16, o_hl} = 3'b011;
    xfer(1'b1, 24'hABCDEF, 16'h2468);
    check(ale_n, 3);
    check(gap_n, 5);
    check(at_ale, 16'hCDEF);
    {c_as, c_ah, c_rs, c_rsb, o_hr, c_rh} = {6'h00, 6'h02, 6'h01, 6'h01,
                                            1'b1, 6'h01};
    xfer(1'b0, 24'hABCDEF, 16'h0000);
    check(ale_n, 1);
    check(gap_n, 4);
    check(stb_n, 3);
    check(hold_n, 2);
    check(rsp_n, 1);
    check(rd, 16'h2468);
    {m_h16, o_hl, o_hr} = 3'b000;
    $display("test multiplexed done");
  endtask : t_mux

  task automatic t_page;
    {m_pg, c_rs, c_rsb, c_pa, c_rh} = {1'b1, 6'h00, 6'h03, 6'h01, 6'h00};
    xfer(1'b0, 24'h001200, 16'h0000);
    check(gap_n, 0);
    check(stb_n, 8);
    xfer(1'b0, 24'h0012FE, 16'h0000);
    check(stb_n, 4);
    xfer(1'b1, 24'h001210, 16'hC0DE);
    xfer(1'b0, 24'h001200, 16'h0000);
    check(stb_n, 8);
    check(rd, 16'hC0DE);
    m_pg = 1'b0;
    $display("test page done");
  endtask : t_page

  task automatic t_ready;
    {m_rw, c_rsb, c_wst, wait_clks} = {1'b1, 6'h00, 6'h00, 8'h06};
    xfer(1'b0, 24'h000040, 16'h0000);
    check(stb_n > 6 && stb_n <= 10, 1'b1);
    xfer(1'b1, 24'h000040, 16'h7777);
    check(stb_n > 6 && stb_n <= 10, 1'b1);
    {wait_clks, m_nd} = {8'h00, 1'b1};
    xfer(1'b0, 24'h000040, 16'h0000);
    check(stb_n, 2);
    check(rsp_n, 1);
    {m_rw, m_nd} = 2'b00;
    $display("test ready done");
  endtask : t_ready

  task automatic t_buffer;
    int   n;
    int   edges;
    logic prev;
    {c_ws, c_wst, c_wh} = {6'h02, 6'h02, 6'h02};
    n = 0;
    edges = 0;
    prev = 1'b0;
    req_valid = 1'b1;
    req_write = 1'b1;
    while (req_ready === 1'b1 && n < 10) begin
      req_addr = 24'h000100 + 24'(n);
      @(negedge clock);
      n++;
    end
    req_valid = 1'b0;
    check(n < 10, 1'b1);
    repeat (300) begin
      if ((write_strobe === m_sah) && !prev) edges++;
      prev = (write_strobe === m_sah);
      @(negedge clock);
    end
    check(edges, n);
    check(busy, 1'b0);
    $display("test buffer done");
  endtask : t_buffer

  initial begin
    {req_valid, req_write, req_addr, req_wdata} = '0;
    {req_cs, req_bl} = {4'h1, 2'h3};
    {c_ws, c_wst, c_wh, c_as, c_ah, c_rs, c_rsb, c_rh, c_pa} = '0;
    {o_hw, o_hl, o_hr, m_pg, m_b8, m_h16, m_nd, m_rw} = '0;
    {m_sah, m_sh, wait_clks} = {2'b11, 8'h00};
    repeat (6) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    t_write();
    t_polarity();
    t_mux();
    t_page();
    t_ready();
    t_buffer();
    finish_test();
  end
endmodule : ebst_top_tb_top
